//--- rtl/tws_engine.sv
// two-wire master/slave engine with axi4-lite register slave
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module tws_engine
	import tws_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_ce,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [7:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	input  wire logic        i_scl,
	output logic             o_scl,
	output logic             o_scl_oe,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe,
	output logic [1:0]       o_port_mode_high_select,
	output logic [1:0]       o_port_mode_low_select,
	output logic             o_port_schmitt_select
);
	import tws_pkg::*;

	typedef struct packed {
		logic        en;
		logic        sta;
		logic        sto;
		logic        si;
		logic        aa;
		logic [6:0]  own;
		logic        gc;
		logic [7:0]  div;
		logic [7:0]  dat;
		logic        aw_have;
		logic [7:0]  awa;
		logic        w_have;
		logic [31:0] wd;
		logic        ws;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        scl_q;
		logic        sda_q;
		logic        busy;
		tws_ms_t     ms;
		logic [1:0]  ph;
		logic [8:0]  cnt;
		logic        master;
		logic        lost;
		logic        addressed;
		logic        tx;
		logic        addr_ph;
		logic        rw;
		logic        ack;
		logic        gch;
		logic        arm;
		logic [3:0]  bitc;
		logic [7:0]  shf;
		logic        obit;
		logic        drl;
		logic        scl_lo;
		logic        ackdrv;
		logic        rsm;
	} tws_st_t;

	localparam tws_st_t ST_RST = '{div: DIV_RST, ms: MS_IDLE, obit: 1'b1,
		scl_q: 1'b1, sda_q: 1'b1, default: '0};

	tws_st_t    r;
	tws_st_t    n;
	logic [1:0] sy;
	logic       s_scl;
	logic       s_sda;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic [7:0] div_eff;
	logic [8:0] lo9;
	logic [8:0] hi9;
	logic       tick;
	logic       hold;
	logic       hit;
	logic       aw_map;
	logic       awready;
	logic       wready;
	logic       arready;
	logic       data_low;

	// ---------------------------------------------------------------
	// line sampling
	// ---------------------------------------------------------------
	tws_sync #(
		.W(2)
	) u_sync (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_d       ({i_scl, i_sda}),
		.o_q       (sy)
	);

	assign s_scl     = sy[1];
	assign s_sda     = sy[0];
	assign scl_rise  = s_scl & ~r.scl_q;
	assign scl_fall  = ~s_scl & r.scl_q;
	assign start_det = s_scl & r.scl_q & r.sda_q & ~s_sda;
	assign stop_det  = s_scl & r.scl_q & ~r.sda_q & s_sda;

	// ---------------------------------------------------------------
	// bit timing
	// ---------------------------------------------------------------
	// 00H and 01H are clamped: below three cycles the sync delay breaks timing
	assign div_eff = (r.div < DIV_MIN) ? DIV_MIN : r.div;
	assign lo9     = ({1'b0, div_eff} + 9'h001) >> 1;
	assign hi9     = {1'b0, div_eff} + 9'h001 - lo9;
	assign tick    = (r.cnt == ((r.scl_lo ? lo9 : hi9) - 9'h001));
	// first two released cycles are sync latency, not stretching; stretch seen from DIV 4 up
	assign hold    = ~r.scl_lo & ~s_scl & (r.cnt >= 9'h002);

	assign hit = r.aa & (((r.shf[7:1] == r.own) & (r.shf != GC_ADDR))
		| (r.gc & (r.shf == GC_ADDR)));

	assign aw_map = (r.awa == A_CTRL) | (r.awa == A_STAT) | (r.awa == A_DATA)
		| (r.awa == A_ADDR) | (r.awa == A_DIV);

	assign awready = i_ce & ~r.aw_have & ~r.bvalid;
	assign wready  = i_ce & ~r.w_have & ~r.bvalid;
	assign arready = i_ce & ~r.rvalid;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		n = r;
		n.rsm = 1'b0;
		n.scl_q = s_scl;
		n.sda_q = s_sda;

		if (i_awvalid && awready) begin
			n.aw_have = 1'b1;
			n.awa = i_awaddr;
		end
		if (i_wvalid && wready) begin
			n.w_have = 1'b1;
			n.wd = i_wdata;
			n.ws = i_wstrb[0];
		end
		if (r.bvalid && i_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_have && r.w_have) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = aw_map ? RESP_OKAY : RESP_SLVERR;
			if (r.ws) begin
				case (r.awa)
					A_CTRL: begin
						n.en = r.wd[C_EN];
						n.sta = r.wd[C_STA];
						n.sto = r.wd[C_STO];
						n.aa = r.wd[C_AA];
						// only a zero clears the event flag
						if (!r.wd[C_SI] && r.si) begin
							n.si = 1'b0;
							n.rsm = 1'b1;
						end
					end
					A_DATA: n.dat = r.wd[7:0];
					A_ADDR: begin
						n.own = r.wd[7:1];
						n.gc = r.wd[0];
					end
					A_DIV: n.div = r.wd[7:0];
					default: ;
				endcase
			end
		end

		if (i_arvalid && arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h0000_0000;
			case (i_araddr)
				A_CTRL: begin
					n.rdata[C_EN] = r.en;
					n.rdata[C_STA] = r.sta;
					n.rdata[C_STO] = r.sto;
					n.rdata[C_SI] = r.si;
					n.rdata[C_AA] = r.aa;
				end
				A_STAT: begin
					n.rdata[S_BUSY] = r.busy;
					n.rdata[S_MST] = r.master;
					n.rdata[S_ADR] = r.addressed;
					n.rdata[S_TX] = r.tx;
					n.rdata[S_ACK] = r.ack;
					n.rdata[S_LOST] = r.lost;
					n.rdata[S_GC] = r.gch;
					n.rdata[S_RW] = r.rw;
				end
				A_DATA: n.rdata[7:0] = r.dat;
				A_ADDR: n.rdata[7:0] = {r.own, r.gc};
				A_DIV: n.rdata[7:0] = r.div;
				default: n.rresp = RESP_SLVERR;
			endcase
		end else if (r.rvalid && i_rready) begin
			n.rvalid = 1'b0;
		end

		if (!r.en) begin
			n.ms = MS_IDLE;
			n.master = 1'b0;
			n.addressed = 1'b0;
			n.busy = 1'b0;
			n.drl = 1'b0;
			n.scl_lo = 1'b0;
			n.ackdrv = 1'b0;
			n.bitc = 4'h0;
			n.cnt = 9'h000;
		end else begin
			// master condition and clock generator
			case (r.ms)
				MS_IDLE: begin
					n.cnt = 9'h000;
					n.ph = 2'h0;
					if (r.sta && !r.busy && s_sda && s_scl && !r.si) begin
						n.ms = MS_START;
						n.master = 1'b1;
						n.lost = 1'b0;
						n.drl = 1'b1;
					end
				end
				MS_RUN: begin
					if (r.si) begin
						n.cnt = 9'h000;
					end else if (!hold) begin
						if (tick) begin
							n.cnt = 9'h000;
							n.scl_lo = ~r.scl_lo;
						end else begin
							n.cnt = r.cnt + 9'h001;
						end
					end
					if (r.rsm && r.sto) begin
						n.ms = MS_STOP;
						n.ph = 2'h0;
						n.cnt = 9'h000;
						n.drl = 1'b1;
					end else if (r.rsm && r.sta) begin
						n.ms = MS_RSTRT;
						n.ph = 2'h0;
						n.cnt = 9'h000;
						n.drl = 1'b0;
					end
				end
				default: begin
					if (!hold) begin
						if (tick) begin
							n.cnt = 9'h000;
							n.ph = r.ph + 2'h1;
						end else begin
							n.cnt = r.cnt + 9'h001;
						end
					end
					if (!hold && tick) begin
						case ({r.ms, r.ph})
							{MS_STOP, 2'h0}, {MS_RSTRT, 2'h0}: n.scl_lo = 1'b0;
							{MS_STOP, 2'h1}: n.drl = 1'b0;
							{MS_RSTRT, 2'h1}: n.drl = 1'b1;
							{MS_START, 2'h0}, {MS_RSTRT, 2'h2}: begin
								n.scl_lo = 1'b1;
								n.ms = MS_RUN;
								n.drl = 1'b0;
								n.si = 1'b1;
								n.tx = 1'b1;
								n.addr_ph = 1'b1;
								n.bitc = 4'h0;
								n.arm = 1'b0;
							end
							default: n.ph = r.ph;
						endcase
					end
				end
			endcase

			// byte engine driven by observed clock edges
			if (start_det) begin
				n.busy = 1'b1;
				n.bitc = 4'h0;
				n.arm = 1'b0;
				n.addr_ph = 1'b1;
				n.addressed = 1'b0;
				n.gch = 1'b0;
				n.tx = r.master;
			end
			if (scl_rise && r.busy) begin
				n.arm = 1'b1;
				if (r.bitc < 4'h8) begin
					n.shf = {r.shf[6:0], s_sda};
					if (r.master && !r.lost && r.tx && r.obit && !s_sda) begin
						n.lost = 1'b1;
					end
				end else begin
					n.ack = ~s_sda;
				end
			end
			if (scl_fall && r.busy && r.arm) begin
				if (r.bitc < 4'h7) begin
					n.bitc = r.bitc + 4'h1;
					n.obit = r.shf[7];
				end else if (r.bitc == 4'h7) begin
					n.bitc = 4'h8;
					n.dat = r.shf;
					n.obit = 1'b1;
					if (r.addr_ph) begin
						n.rw = r.shf[0];
						if (!(r.master && !r.lost) && hit) begin
							n.addressed = 1'b1;
							n.gch = (r.shf == GC_ADDR);
							n.ackdrv = 1'b1;
						end
					end else begin
						n.ackdrv = r.aa & ~r.tx
							& ((r.master & ~r.lost) | r.addressed);
					end
				end else begin
					n.bitc = 4'h0;
					n.ackdrv = 1'b0;
					n.obit = 1'b1;
					if (r.master && r.lost) begin
						n.master = 1'b0;
						n.ms = MS_IDLE;
						n.scl_lo = 1'b0;
						n.cnt = 9'h000;
					end
					if (r.master && !r.lost) begin
						n.si = 1'b1;
					end else if (r.addressed) begin
						n.si = 1'b1;
						if (r.tx ? !r.ack : !r.ackdrv) begin
							n.addressed = 1'b0;
						end
					end
					if (r.addr_ph) begin
						n.addr_ph = 1'b0;
						n.tx = (r.master && !r.lost) ? ~r.rw : r.rw;
					end
				end
			end
			if (r.rsm && r.tx) begin
				n.shf = r.dat;
				n.obit = r.dat[7];
			end
			if (stop_det) begin
				n.busy = 1'b0;
				n.master = 1'b0;
				n.addressed = 1'b0;
				n.lost = 1'b0;
				n.ms = MS_IDLE;
				n.sto = 1'b0;
				n.drl = 1'b0;
				n.scl_lo = 1'b0;
				n.ackdrv = 1'b0;
				n.obit = 1'b1;
				n.bitc = 4'h0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r <= ST_RST;
		end else if (i_ce) begin
			r <= n;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// a lost master stops driving data at once but keeps the clock until the ninth pulse of the byte ends
	assign data_low = r.tx & ~r.obit & (r.bitc < 4'h8)
		& ((r.master & ~r.lost) | (r.addressed & ~r.master));

	assign o_sda    = 1'b0;
	assign o_scl    = 1'b0;
	assign o_sda_oe = r.en & ((r.ms == MS_RUN || r.ms == MS_IDLE)
		? (data_low | (r.ackdrv & (r.bitc == 4'h8))) : r.drl);
	assign o_scl_oe = r.en & ((r.master & r.scl_lo)
		| (r.si & r.addressed));

	assign o_port_mode_high_select = r.en ? OD_MODE : PIN_MODE;
	assign o_port_mode_low_select  = r.en ? OD_MODE : PIN_MODE;
	assign o_port_schmitt_select   = r.en;

	assign o_awready = awready;
	assign o_wready  = wready;
	assign o_bvalid  = r.bvalid;
	assign o_bresp   = r.bresp;
	assign o_arready = arready;
	assign o_rvalid  = r.rvalid;
	assign o_rdata   = r.rdata;
	assign o_rresp   = r.rresp;
endmodule

//--- rtl/tws_pkg.sv
// constants, field layout and state encoding of the two-wire engine
package tws_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_DATA = 8'h08;
	localparam logic [7:0] A_ADDR = 8'h0C;
	localparam logic [7:0] A_DIV  = 8'h10;

	localparam int C_EN  = 0;
	localparam int C_STA = 1;
	localparam int C_STO = 2;
	localparam int C_SI  = 3;
	localparam int C_AA  = 4;

	localparam int S_BUSY = 0;
	localparam int S_MST  = 1;
	localparam int S_ADR  = 2;
	localparam int S_TX   = 3;
	localparam int S_ACK  = 4;
	localparam int S_LOST = 5;
	localparam int S_GC   = 6;
	localparam int S_RW   = 7;

	localparam logic [7:0] DIV_RST = 8'h0E;
	localparam logic [7:0] DIV_MIN = 8'h02;
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] OD_MODE     = 2'h3;
	localparam logic [1:0] PIN_MODE    = 2'h0;

	// ---------------------------------------------------------------
	// bus rates
	// ---------------------------------------------------------------
	localparam int CLK_HZ   = 50_000_000;
	localparam int STD_BPS  = 100_000;
	localparam int FAST_BPS = 400_000;
	localparam int DIV_STD  = CLK_HZ / STD_BPS - 1;
	localparam int DIV_FAST = CLK_HZ / FAST_BPS - 1;

	typedef enum logic [2:0] {
		MS_IDLE  = 3'h0,
		MS_START = 3'h1,
		MS_RUN   = 3'h3,
		MS_STOP  = 3'h2,
		MS_RSTRT = 3'h7
	} tws_ms_t;

endpackage

//--- rtl/tws_sync.sv
// two-stage synchroniser for the bus lines
`timescale 1ns/10ps
module tws_sync #(
	parameter int W = 2
) (
	input  wire logic         i_mclk,
	input  wire logic         i_reset_n,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] q1;
		logic [W-1:0] q2;
	} tws_sy_t;

	tws_sy_t r;
	tws_sy_t n;

	// idle bus level is high, so reset to ones
	always_comb begin
		n = r;
		n.q1 = i_d;
		n.q2 = r.q1;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r <= '1;
		end else if (i_ce) begin
			r <= n;
		end
	end

	assign o_q = r.q2;
endmodule

//--- verification/tws_chk.sv
// port assertions for the two-wire engine
`timescale 1ns/10ps
module tws_chk (
	input wire logic       i_mclk,
	input wire logic       i_reset_n,
	input wire logic       i_scl,
	input wire logic       i_sda,
	input wire logic       o_scl,
	input wire logic       o_sda,
	input wire logic       o_scl_oe,
	input wire logic       o_sda_oe,
	input wire logic [1:0] o_port_mode_high_select,
	input wire logic [1:0] o_port_mode_low_select,
	input wire logic       o_port_schmitt_select
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// data edges while the clock line is high
	sequence start_s; $rose(o_sda_oe) && i_scl; endsequence
	sequence stop_s; $fell(o_sda_oe) && i_scl && $past(i_scl); endsequence
	AST_OD_LOW: assert property (!o_scl && !o_sda)
		else $error("open-drain data not low");
	AST_MODE:
		assert property ({o_port_mode_high_select, o_port_mode_low_select}
			== {4{o_port_schmitt_select}}) else $error("port mode not open drain");
	AST_RELEASED:
		assert property (!o_port_schmitt_select && !$past(o_port_schmitt_select)
			|-> !o_sda_oe && !o_scl_oe) else $error("lines pulled while disabled");
	AST_START_FREE: assert property (start_s |-> $past(i_sda) && $past(i_scl))
		else $error("start without free lines");
	AST_START_HOLD: assert property (start_s |-> o_sda_oe until o_scl_oe)
		else $error("data released before clock low");
	AST_START_CLK: assert property (start_s |-> ##[1:1000] o_scl_oe)
		else $error("no clock after start");
	AST_STOP_QUIET: assert property (stop_s |=> !o_scl_oe [*4])
		else $error("clock pulled after stop");
	AST_STOP_FREE: assert property (stop_s |-> !o_sda_oe ##1 !o_sda_oe)
		else $error("data pulled right after stop");
endmodule

bind tws_engine tws_chk u_tws_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_scl(i_scl),
	.i_sda(i_sda), .o_scl(o_scl), .o_sda(o_sda), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
	.o_port_mode_high_select(o_port_mode_high_select),
	.o_port_mode_low_select(o_port_mode_low_select),
	.o_port_schmitt_select(o_port_schmitt_select));

//--- verification/tws_slave_model.sv
// behavioural slave device on the two-wire bus
`timescale 1ns/10ps
module tws_slave_model #(
	parameter logic [6:0] SADR = 7'h2C,
	parameter logic [7:0] TX0  = 8'hA5
) (
	input  wire logic       i_mclk,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_slow,
	output logic            o_scl_oe,
	output logic            o_sda_oe,
	output logic [7:0]      o_last
);
	logic       ps = 1'b1, pd = 1'b1, act = 1'b0, rd = 1'b0, fst = 1'b0, nak = 1'b0;
	logic [7:0] sh = 8'h00, tx = 8'h00, nx = TX0;
	int         bn = 0, hold = 0;
	initial begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
		o_last = 8'h00;
	end
	always @(posedge i_mclk) begin
		ps <= i_scl;
		pd <= i_sda;
		if (hold > 0) hold <= hold - 1;
		if (hold == 1) o_scl_oe <= 1'b0;
		if (ps && i_scl && pd && !i_sda) begin
			bn <= 0;
			fst <= 1'b1;
			act <= 1'b0;
		end else if (ps && i_scl && !pd && i_sda) begin
			act <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (!ps && i_scl) begin // msb first, ack on ninth pulse
			if (bn < 8) sh <= {sh[6:0], i_sda};
			else nak <= i_sda;
			bn <= bn + 1;
		end else if (ps && !i_scl) begin
			if (bn == 8 && fst) begin // ack own address only
				act <= sh[7:1] == SADR;
				rd <= sh[0];
				o_sda_oe <= sh[7:1] == SADR;
			end else if (bn == 8) begin // transmitter lets go for the ack
				if (act && !rd) o_last <= sh;
				o_sda_oe <= act && !rd;
			end else if (bn == 9) begin
				bn <= 0;
				fst <= 1'b0;
				if (i_slow) begin // stretch after ninth pulse
					o_scl_oe <= 1'b1;
					hold <= 300;
				end
				if (act && rd && !nak) begin
					o_sda_oe <= !nx[7];
					tx <= {nx[6:0], 1'b0};
					nx <= nx + 8'h01;
				end else begin // nack ends a read
					o_sda_oe <= 1'b0;
					if (rd) act <= 1'b0;
				end
			end else if (act && rd && !fst) begin
				o_sda_oe <= !tx[7];
				tx <= {tx[6:0], 1'b0};
			end
		end
	end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the two-wire engine
`timescale 1ns/10ps
module tb_top;
	import tws_pkg::*;
	localparam logic [6:0]  SADR  = 7'h2C;
	localparam logic [7:0]  TX0   = 8'hA5;
	localparam int          DV    = 9;
	localparam logic [31:0] K_EN  = 32'h0000_0001;
	localparam logic [31:0] K_GO  = 32'h0000_0011;
	localparam logic [31:0] K_STA = 32'h0000_0013;
	localparam logic [31:0] K_STO = 32'h0000_0015;
	logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
	logic        arv = 1'b0, rr = 1'b0, slow = 1'b0, scl_q = 1'b1;
	logic [7:0]  awa = 8'h00, ara = 8'h00, mlast;
	logic [31:0] wd = 32'h0000_0000, rd;
	logic        awr, wr, bv, arr, rv, dso, dco, mso, mco, scl, sda, sch;
	logic [1:0]  bresp, rresp, pmh, pml;
	int          miscompares = 0, n_compared = 0, rises = 0, gap = 0, cnt = 0;
	assign scl = !(dco | mco);
	assign sda = !(dso | mso);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		scl_q <= scl;
		cnt <= cnt + 1;
		if (scl && !scl_q) begin
			rises <= rises + 1;
			gap <= cnt;
			cnt <= 1;
		end
	end
	tws_engine u_tws_engine (.i_mclk(clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_awvalid(awv),
		.o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr), .i_wdata(wd),
		.i_wstrb(4'hf), .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv),
		.o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rd),
		.o_rresp(rresp), .i_scl(scl), .o_scl(), .o_scl_oe(dco), .i_sda(sda), .o_sda(),
		.o_sda_oe(dso), .o_port_mode_high_select(pmh), .o_port_mode_low_select(pml),
		.o_port_schmitt_select(sch));
	tws_slave_model #(.SADR(SADR), .TX0(TX0)) u_tws_slave_model (.i_mclk(clk), .i_scl(scl),
		.i_sda(sda), .i_slow(slow), .o_scl_oe(mco), .o_sda_oe(mso), .o_last(mlast));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awr) awv <= 1'b0;
			if (pa && awr) pa = 1'b0;
			if (pw && wr) wv <= 1'b0;
			if (pw && wr) pw = 1'b0;
		end
		while (bv !== 1'b1) @(posedge clk);
		r = bresp;
		br <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		while (rv !== 1'b1) @(posedge clk);
		d = rd;
		r = rresp;
		rr <= 1'b0;
	endtask
	task automatic ctl(input logic [31:0] d);
		logic [1:0] r;
		axw(A_CTRL, d, r);
	endtask
	task automatic wait_ev;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		d = 0;
		n = 0;
		while (d[C_SI] !== 1'b1 && n < 300) begin
			axr(A_CTRL, d, r);
			n++;
		end
		chk(d[C_SI], 1, "event flag");
		chk(scl, 0, "clock held while flag set");
	endtask
	task automatic xfer(input logic [31:0] c, output logic [31:0] st);
		logic [1:0] r;
		int r0;
		r0 = rises;
		ctl(c);
		wait_ev;
		chk(rises - r0, 9, "pulses per byte");
		chk(gap, DV + 1, "bit period");
		axr(A_STAT, st, r);
	endtask
	task automatic open(input logic [7:0] a, output logic [31:0] st);
		logic [1:0] r;
		ctl(K_STA);
		wait_ev;
		axw(A_DATA, {24'h00_0000, a}, r);
		xfer(K_GO, st);
	endtask
	task automatic close;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		d = 32'h0000_0001;
		ctl(K_STO);
		while (d[S_BUSY] !== 1'b0 && n < 100) begin
			axr(A_STAT, d, r);
			n++;
		end
		chk(d[S_MST], 0, "master after stop");
		chk(d[S_BUSY], 0, "bus free after stop");
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axr(A_DIV, d, r);
		chk(d, {24'h00_0000, DIV_RST}, "divider reset");
		axr(A_ADDR, d, r);
		chk(d, 0, "address reset");
		axw(A_ADDR, 32'h0000_006A, r);
		axr(A_ADDR, d, r);
		chk(d, 32'h0000_006A, "own address readback");
		axr(8'h14, d, r);
		chk(r, RESP_SLVERR, "unmapped read");
		axw(8'h14, 32'hFFFF_FFFF, r);
		chk(r, RESP_SLVERR, "unmapped write");
		axw(A_STAT, 32'h0000_00FF, r);
		axr(A_STAT, d, r);
		chk(d, 0, "status read only");
		chk({pmh, pml, sch}, 0, "pins idle");
		axw(A_DIV, DV, r);
		chk({scl, sda}, 2'b11, "lines high before enable");
		ctl(K_GO);
		chk({pmh, pml, sch}, {OD_MODE, OD_MODE, 1'b1}, "open drain");
		$display("test regs done");
	endtask
	task automatic t_master;
		logic [31:0] st;
		logic [1:0] r;
		open({SADR, 1'b0}, st);
		chk(st[S_ACK] & st[S_MST], 1, "address ack");
		axw(A_DATA, 32'h0000_003C, r);
		xfer(K_GO, st);
		chk(mlast, 8'h3C, "written byte");
		open({SADR, 1'b1}, st);
		chk(st[S_RW], 1, "read direction");
		xfer(K_GO, st);
		axr(A_DATA, st, r);
		chk(st, TX0, "first read byte");
		xfer(K_EN, st);
		axr(A_DATA, st, r);
		chk(st, TX0 + 8'h01, "last read byte");
		close;
		chk(mso, 0, "slave let go");
		$display("test master done");
	endtask
	task automatic t_nack;
		logic [31:0] st;
		open({SADR ^ 7'h01, 1'b0}, st);
		chk(st[S_ACK], 0, "absent address");
		close;
		$display("test nack done");
	endtask
	task automatic t_stretch;
		logic [31:0] st;
		logic [1:0] r;
		slow <= 1'b1;
		open({SADR, 1'b0}, st);
		axw(A_DATA, 32'h0000_00C3, r);
		xfer(K_GO, st);
		chk(mlast, 8'hC3, "byte after stretch");
		close;
		slow <= 1'b0;
		$display("test stretch done");
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_master;
		t_nack;
		t_stretch;
		tally_and_finish;
	end
	// whole run takes a few thousand cycles
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		tally_and_finish;
	end
endmodule
